/* verilog/card_irq_pkg.sv */
// package: register map, field positions and reset values of the card event block
package card_irq_pkg;
   localparam int unsigned addr_w = 12;
   localparam logic [addr_w-1:0] event_source_off = 12'h000;
   localparam logic [addr_w-1:0] event_mask_off = 12'h004;
   localparam logic [addr_w-1:0] event_clear_off = 12'h008;
   localparam int unsigned src_w = 20;
   localparam int unsigned bit_line3_level = 19;
   localparam int unsigned bit_card_irq = 18;
   localparam int unsigned bit_data_done = 17;
   localparam int unsigned bit_data_crc = 16;
   localparam int unsigned bit_resp_ready = 15;
   localparam int unsigned bit_resp_crc = 14;
   localparam int unsigned bit_line3_low_flag = 13;
   localparam int unsigned bit_line3_high_flag = 12;
   localparam int unsigned bit_cmd_sent = 11;
   localparam int unsigned bit_busy_end = 10;
   localparam int unsigned lo_bit = 10;
   localparam int unsigned n_latched = 6;
   localparam logic [31:0] event_source_rst = 32'h0000_0000;
   localparam logic [18:0] event_mask_rst = 19'h7_ffff;
   localparam logic [1:0] resp_okay = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;
   typedef enum logic [1:0] {wr_idle, wr_resp} wr_state_t;
endpackage : card_irq_pkg

/* verilog/pin_sync.sv */
// module: two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned width = 1
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);
   logic [width-1:0] meta_r;

   // meta_r is read by sync_out only
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : pin_sync

/* verilog/card_host_interrupt_status.sv */
// module: card host event flags, mask, clear and interrupt pin over AXI4-Lite
//
// How it works
// - source register at 0x00 shows raw unmasked event flags for polling
// - software reads the source register to see why interrupt asserted
// - bit 19 is no event; it shows live data line 3 level
// - bit 18 shows card interrupt; maskable, clear register ignores it
// - bit 17 sets when a card data read or write finishes
// - bit 16 sets when a data transfer crc check fails
// - bit 15 sets when a response is stored and ready to read
// - bit 14 sets when a received response crc check fails
// - bit 13 high while data machine idle and line 3 low
// - bit 12 high while data machine idle and line 3 high
// - bit 11 sets once the command is fully sent to the card
// - bit 10 sets when the card stops signalling busy
// - mask register at 0x04, 1 masks a source, all masked at reset
`timescale 1ns/1ps
module card_host_interrupt_status
   import card_irq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   // axi4-lite slave
   input wire logic [card_irq_pkg::addr_w-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [card_irq_pkg::addr_w-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // one-cycle event pulses and the data machine idle level from the card engine (same clock)
   input wire logic data_done_pulse,
   input wire logic data_crc_fail_pulse,
   input wire logic resp_ready_pulse,
   input wire logic resp_crc_fail_pulse,
   input wire logic cmd_sent_pulse,
   input wire logic busy_end_pulse,
   input wire logic data_fsm_idle,
   // card pins (asynchronous) and the registered interrupt pin
   input wire logic card_data_line_three,
   input wire logic card_irq_level,
   output logic irq
);
   import card_irq_pkg::*;

   // ----------------------------------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic rst_meta_r;
   logic rst_sync_b;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_r <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_b <= rst_meta_r;
      end
   end

   logic [1:0] pins_s;
   logic line3_level;
   logic card_irq_s;
   pin_sync #(.width(2)) u_pin_sync (
      .core_clk(core_clk),
      .rst_b(rst_sync_b),
      .async_in({card_irq_level, card_data_line_three}),
      .sync_out(pins_s)
   );
   assign line3_level = pins_s[0];
   assign card_irq_s = pins_s[1];

   // ----------------------------------------------------------------
   // axi4-lite write path
   // ----------------------------------------------------------------
   logic aw_held_r;
   logic w_held_r;
   logic [addr_w-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_fire;
   logic [1:0] bresp_r;
   logic bvalid_r;

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         aw_held_r <= 1'b0;
         awaddr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         w_held_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end
   end

   logic wr_map_hit;
   assign wr_map_hit = awaddr_r[addr_w-1:2] == event_source_off[addr_w-1:2]
      || awaddr_r[addr_w-1:2] == event_mask_off[addr_w-1:2]
      || awaddr_r[addr_w-1:2] == event_clear_off[addr_w-1:2];

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         bvalid_r <= 1'b0;
         bresp_r <= resp_okay;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_map_hit ? resp_okay : resp_slverr;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // byte-lane expanded write data
   logic [31:0] wmask;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = wstrb_r[i] ? wdata_r[i*8 +: 8] : 8'h00;
      end
   end

   logic mask_we;
   logic clear_we;
   assign mask_we = wr_fire
      && awaddr_r[addr_w-1:2] == event_mask_off[addr_w-1:2];
   assign clear_we = wr_fire
      && awaddr_r[addr_w-1:2] == event_clear_off[addr_w-1:2];

   // ----------------------------------------------------------------
   // mask register
   // ----------------------------------------------------------------
   logic [18:0] event_mask_r;
   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         event_mask_r <= event_mask_rst;
      end else if (mask_we) begin
         // lane 2 holds only bits 18..16; its upper bits have no storage
         if (wstrb_r[0]) begin
            event_mask_r[7:0] <= wdata_r[7:0];
         end
         if (wstrb_r[1]) begin
            event_mask_r[15:8] <= wdata_r[15:8];
         end
         if (wstrb_r[2]) begin
            event_mask_r[18:16] <= wdata_r[18:16];
         end
      end
   end

   // ----------------------------------------------------------------
   // latched event flags, bits 17..14, 11, 10
   // ----------------------------------------------------------------
   // index order: busy_end, cmd_sent, resp_crc, resp_ready, data_crc,
   // data_done; positions are lo_bit plus a gap for bits 12 and 13
   logic [n_latched-1:0] ev_pulse;
   logic [n_latched-1:0] ev_clr;
   logic [n_latched-1:0] ev_flag_r;
   assign ev_pulse = {data_done_pulse, data_crc_fail_pulse,
      resp_ready_pulse, resp_crc_fail_pulse, cmd_sent_pulse,
      busy_end_pulse};
   assign ev_clr = clear_we ? {wmask[bit_data_done:bit_resp_crc],
      wmask[bit_cmd_sent:bit_busy_end]} : '0;

   genvar g;
   generate
      for (g = 0; g < n_latched; g++) begin : g_flag
         // a new event wins over a clear in the same cycle
         always_ff @(posedge core_clk or negedge rst_sync_b) begin
            if (!rst_sync_b) begin
               ev_flag_r[g] <= 1'b0;
            end else if (ev_pulse[g]) begin
               ev_flag_r[g] <= 1'b1;
            end else if (ev_clr[g]) begin
               ev_flag_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // source word and interrupt
   // ----------------------------------------------------------------
   logic [src_w-1:0] source;
   always_comb begin
      source = '0;
      source[bit_line3_level] = line3_level;
      source[bit_card_irq] = card_irq_s;
      source[bit_data_done:bit_resp_crc] = ev_flag_r[5:2];
      source[bit_line3_low_flag] = data_fsm_idle && !line3_level;
      source[bit_line3_high_flag] = data_fsm_idle && line3_level;
      source[bit_cmd_sent] = ev_flag_r[1];
      source[bit_busy_end] = ev_flag_r[0];
   end

   logic irq_r;
   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(source[18:0] & ~event_mask_r);
      end
   end
   assign irq = irq_r;

   // ----------------------------------------------------------------
   // axi4-lite read path
   // ----------------------------------------------------------------
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rvalid_r <= 1'b0;
         rdata_r <= event_source_rst;
         rresp_r <= resp_okay;
      end else if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rresp_r <= resp_okay;
         if (s_axi_araddr[addr_w-1:2] == event_source_off[addr_w-1:2]) begin
            rdata_r <= {12'h000, source};
         end else if (s_axi_araddr[addr_w-1:2]
                      == event_mask_off[addr_w-1:2]) begin
            rdata_r <= {13'h0000, event_mask_r};
         end else if (s_axi_araddr[addr_w-1:2]
                      == event_clear_off[addr_w-1:2]) begin
            rdata_r <= 32'h0000_0000;
         end else begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= resp_slverr;
         end
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_done_evt;
      data_done_pulse;
   endsequence

   a_done_sets_flag: assert property (
      @(posedge core_clk) disable iff (!rst_sync_b)
      s_done_evt |=> ev_flag_r[5])
      else $error("data done flag not set");
   a_crc_sets_flag: assert property (
      @(posedge core_clk) disable iff (!rst_sync_b)
      data_crc_fail_pulse |=> ev_flag_r[4])
      else $error("data crc flag not set");
   a_resp_sets_flag: assert property (
      @(posedge core_clk) disable iff (!rst_sync_b)
      resp_ready_pulse |=> source[bit_resp_ready])
      else $error("response flag not set");
   a_cmd_sets_flag: assert property (
      @(posedge core_clk) disable iff (!rst_sync_b)
      cmd_sent_pulse |=> source[bit_cmd_sent])
      else $error("command sent flag not set");
   a_busy_sets_flag: assert property (
      @(posedge core_clk) disable iff (!rst_sync_b)
      busy_end_pulse |=> source[bit_busy_end])
      else $error("busy end flag not set");
   a_clear_drops_flag: assert property (
      @(posedge core_clk) disable iff (!rst_sync_b)
      clear_we && wmask[bit_resp_crc] && !resp_crc_fail_pulse
      |=> !source[bit_resp_crc])
      else $error("clear did not drop flag");
   a_line3_flags: assert property (
      @(posedge core_clk) disable iff (!rst_sync_b)
      data_fsm_idle |-> source[bit_line3_high_flag] == line3_level
         && source[bit_line3_low_flag] == !line3_level)
      else $error("line3 flags wrong while idle");
   a_line3_quiet: assert property (
      @(posedge core_clk) disable iff (!rst_sync_b)
      !data_fsm_idle |-> !source[bit_line3_low_flag]
         && !source[bit_line3_high_flag])
      else $error("line3 flags set while busy");
   a_irq_follows: assert property (
      @(posedge core_clk) disable iff (!rst_sync_b)
      ##1 irq == $past(|(source[18:0] & ~event_mask_r)))
      else $error("interrupt pin wrong");
   a_mask_reset: assert property (
      @(posedge core_clk)
      $rose(rst_sync_b) |-> event_mask_r == event_mask_rst && !irq)
      else $error("mask not all set after reset");
endmodule : card_host_interrupt_status

/* dv/card_model.sv */
// file: behavioural card that drives data line 3 and its interrupt pin
`timescale 1ns/1ps
module card_model (
   input wire logic line3_req,
   input wire logic irq_req,
   output logic card_data_line_three,
   output logic card_irq_level
);
   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   initial begin
      card_data_line_three = 1'b0;
      card_irq_level = 1'b0;
   end
   // edges land off the host clock grid, as a real card's would
   always @(line3_req) begin
      card_data_line_three <= #1.7 line3_req;
   end
   // only the card withdraws its own interrupt; the host cannot
   always @(irq_req) begin
      card_irq_level <= #2.3 irq_req;
   end
endmodule : card_model

/* dv/card_host_interrupt_status_tb.sv */
// file: register-level testbench for the card event block
`timescale 1ns/1ps
module card_host_interrupt_status_tb;
   import card_irq_pkg::*;
   logic core_clk, rst_b;
   logic [addr_w-1:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [5:0] ev;
   logic idle, line3_req, irq_req, line3, card_irq;
   int failures, samples_checked, cyc;
   // ------------------------------------------------------------
   // design and card
   // ------------------------------------------------------------
   card_host_interrupt_status uut (.core_clk(core_clk), .rst_b(rst_b),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .data_done_pulse(ev[5]), .data_crc_fail_pulse(ev[4]),
      .resp_ready_pulse(ev[3]), .resp_crc_fail_pulse(ev[2]),
      .cmd_sent_pulse(ev[1]), .busy_end_pulse(ev[0]),
      .data_fsm_idle(idle), .card_data_line_three(line3),
      .card_irq_level(card_irq), .irq(irq));
   card_model card (.line3_req(line3_req), .irq_req(irq_req),
      .card_data_line_three(line3), .card_irq_level(card_irq));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // ------------------------------------------------------------
   // bus tasks and checking
   // ------------------------------------------------------------
   // ready is looked at mid-cycle; inputs only move just after a rise
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge core_clk);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(negedge core_clk);
         aw_done = aw_done | (awvalid & awready);
         w_done = w_done | (wvalid & wready);
         @(posedge core_clk);
         if (aw_done) awvalid <= 1'b0;
         if (w_done) wvalid <= 1'b0;
      end
      do @(negedge core_clk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge core_clk);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge core_clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(negedge core_clk); while (arready !== 1'b1);
      @(posedge core_clk);
      arvalid <= 1'b0;
      do @(negedge core_clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      rready <= 1'b0;
   endtask : rd
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : check
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out
   // a whole run needs about 300 cycles; the ceiling leaves slack
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         close_out();
      end
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      int i;
      int bitpos [6];
      logic [31:0] d, e;
      logic [1:0] r;
      bitpos = '{10, 11, 14, 15, 16, 17};
      rst_b = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0;
      wstrb = 4'hf; wvalid = 1'b0; bready = 1'b0; araddr = '0;
      arvalid = 1'b0; rready = 1'b0; ev = '0; idle = 1'b0;
      line3_req = 1'b0; irq_req = 1'b0; cyc = 0;
      failures = 0; samples_checked = 0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(event_source_off, d, r); check(d, 32'h0);
      rd(event_mask_off, d, r); check(d, 32'h7_ffff);
      wr(event_source_off, 32'hffff_ffff, r); check(r, resp_okay);
      rd(event_source_off, d, r); check(d, 32'h0);
      wr(12'h00c, 32'h0, r); check(r, resp_slverr);
      rd(12'h00c, d, r); check({d[29:0], r}, {30'h0, resp_slverr});
      wstrb <= 4'h4;
      wr(event_mask_off, 32'h0, r);
      wstrb <= 4'hf;
      rd(event_mask_off, d, r); check(d, 32'h0_ffff);
      wr(event_mask_off, 32'hffff_ffff, r);
      rd(event_mask_off, d, r); check(d, 32'h7_ffff);
      for (i = 0; i < 6; i++) begin
         e = 32'h1 << bitpos[i];
         @(posedge core_clk) ev <= 6'h1 << i;
         @(posedge core_clk) ev <= 6'h0;
         rd(event_source_off, d, r); check(d, e);
         check(irq, 1'b0);
         wr(event_mask_off, ~e & 32'h7_ffff, r);
         repeat (2) @(posedge core_clk);
         check(irq, 1'b1);
         wr(event_clear_off, 32'h0, r);
         rd(event_source_off, d, r); check(d, e);
         wr(event_clear_off, e, r);
         rd(event_source_off, d, r); check(d, 32'h0);
         check(irq, 1'b0);
         wr(event_mask_off, 32'h7_ffff, r);
      end
      // line 3 levels: pin crosses two sync stages, so wait generously
      wr(event_mask_off, 32'h0, r);
      line3_req = 1'b1;
      repeat (6) @(posedge core_clk);
      rd(event_source_off, d, r); check(d, 32'h8_0000);
      check(irq, 1'b0);
      wr(event_mask_off, 32'h7_ffff, r);
      @(posedge core_clk) idle <= 1'b1;
      repeat (3) @(posedge core_clk);
      wr(event_clear_off, 32'h000f_3000, r);
      rd(event_source_off, d, r); check(d, 32'h8_1000);
      line3_req = 1'b0;
      repeat (6) @(posedge core_clk);
      rd(event_source_off, d, r); check(d, 32'h0_2000);
      wr(event_mask_off, 32'h7_dfff, r);
      repeat (2) @(posedge core_clk);
      check(irq, 1'b1);
      @(posedge core_clk) idle <= 1'b0;
      repeat (4) @(posedge core_clk);
      rd(event_source_off, d, r); check(d, 32'h0);
      check(irq, 1'b0);
      // card interrupt: maskable, never cleared from the host side
      irq_req = 1'b1;
      repeat (6) @(posedge core_clk);
      wr(event_clear_off, 32'h0004_0000, r);
      rd(event_source_off, d, r); check(d, 32'h4_0000);
      check(irq, 1'b0);
      wr(event_mask_off, 32'h3_ffff, r);
      repeat (2) @(posedge core_clk);
      check(irq, 1'b1);
      irq_req = 1'b0;
      repeat (6) @(posedge core_clk);
      rd(event_source_off, d, r); check(d, 32'h0);
      check(irq, 1'b0);
      close_out();
   end
endmodule : card_host_interrupt_status_tb
